// file: clkgen_regs_pkg.sv
// Register map constants for the clock generator control bank.
// Assumes byte-wide registers addressed by an 8-bit offset.
package clkgen_regs_pkg;
    localparam logic [7:0] DEV_CTRL_OFS   = 8'h05;
    localparam logic [7:0] IN_POL_OFS     = 8'h06;
    localparam logic [7:0] VID_A_FMT_OFS  = 8'h07;
    localparam logic [7:0] VID_B_FMT_OFS  = 8'h08;
    localparam logic [7:0] AUD_XPT_OFS    = 8'h09;
    localparam logic [7:0] OUT_FLOAT_OFS  = 8'h0A;
    localparam logic [7:0] MARK1_HI_OFS   = 8'h0B;
    localparam logic [7:0] MARK1_LO_OFS   = 8'h0C;
    localparam logic [7:0] MARK2_HI_OFS   = 8'h0D;
    localparam logic [7:0] MARK2_LO_OFS   = 8'h0E;
    localparam logic [7:0] MARK3_HI_OFS   = 8'h0F;
    localparam logic [7:0] MARK3_LO_OFS   = 8'h10;

    // Device control bit positions
    localparam int RESTORE_BIT  = 7;
    localparam int SLEEP_BIT    = 6;
    localparam int AUTODET_BIT  = 5;
    localparam int LOOP_MODE_HI = 4;
    localparam int LOOP_MODE_LO = 3;
    localparam int LOSS_POL_BIT = 2;
    localparam int FULL_RATE_BIT = 1;
    localparam int ALL_ON_BIT   = 0;
    // Input polarity and audio mode bit positions
    localparam int AUTO_POL_BIT = 3;
    localparam int AUX4_BIT     = 4;

    localparam logic [6:0] DEV_CTRL_RST  = 7'h25;
    localparam logic [3:0] IN_POL_RST    = 4'h8;
    localparam logic [5:0] VID_A_FMT_RST = 6'h0E;
    localparam logic [5:0] VID_B_FMT_RST = 6'h0E;
    localparam logic [4:0] AUD_XPT_RST   = 5'h00;
    localparam logic [7:0] OUT_FLOAT_RST = 8'h0F;
    localparam logic [12:0] MARK_RST     = 13'h0000;

    localparam logic [5:0] FMT_USER      = 6'h1F;
    localparam logic [5:0] FMT_UNKNOWN   = 6'h3F;

    localparam logic [1:0] LOOP_FREE_RUN = 2'h0;
    localparam logic [1:0] LOOP_GENLOCK  = 2'h1;
    localparam logic [1:0] LOOP_HOLDOVER = 2'h2;
endpackage : clkgen_regs_pkg

// file: clkgen_regs.sv
// Control register bank of the audio/video clock generator.
// Assumes the serial bus front end presents one-cycle byte read and
// write strobes on the same clock; detected polarity comes from a pin.
//
// Overview of operation
// - Writing restore bit resets all registers; bit reads back zero.
// - Control bit 6 drives the sleep port output, default zero.
// - Control bit 5 enables format autodetection, default one.
// - Bits 4:3 pick reference loop mode: free-run, genlock, holdover, reserved.
// - Bit 2 picks loss-of-reference policy: holdover or free run, default one.
// - Bit 1 forces both video loops to the full 148.xx MHz rate.
// - Bit 0 low floats all clock and pulse pins; default one.
// - Auto polarity detects line sync polarity and applies it to all inputs.
// - Manual polarity bits for line, field, frame-id; one is active high.
// - Six-bit video A format field, default 0x0E.
// - Codes 0 to 31 defined, 31 user-defined, 63 unknown.
// - Aux4 select picks secondary audio clock or audio frame sync.
// - Four-bit crosspoint select routes channels two and three, default zero.
// - Clock pin float bits 7:4, one floats pin, default zero.
// - Pulse pin float bits 3:0, one floats pin, default 0xF.
// - First frame mark line delay is 13 bits over two registers.
// - Second frame mark line delay is 13 bits over two registers.
// - Third frame mark line delay is 13 bits over two registers.
`timescale 1ns/10ps
`default_nettype none
module clkgen_regs (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        detected_line_pol_i,
    output logic      [7:0]  rdata_o,
    output logic             rvalid_o,
    output logic             sleep_port_o,
    output logic             format_autodetect_on_o,
    output logic      [1:0]  reference_loop_mode_o,
    output logic             ref_loss_policy_o,
    output logic             force_full_rate_o,
    output logic      [2:0]  sync_polarity_o,
    output logic      [5:0]  video_a_format_o,
    output logic             video_a_user_o,
    output logic             video_a_unknown_o,
    output logic      [5:0]  video_b_format_o,
    output logic             aux4_pulse_select_o,
    output logic      [3:0]  crosspoint_select_o,
    output logic      [3:0]  clock_pin_oe_o,
    output logic      [3:0]  pulse_pin_oe_o,
    output logic      [12:0] mark1_line_delay_o,
    output logic      [12:0] mark2_line_delay_o,
    output logic      [12:0] mark3_line_delay_o
);
    import clkgen_regs_pkg::*;

    logic [6:0]  ctrl_r,  ctrl_nxt;
    logic [3:0]  pol_r,   pol_nxt;
    logic [5:0]  fmta_r,  fmta_nxt;
    logic [5:0]  fmtb_r,  fmtb_nxt;
    logic [4:0]  aud_r,   aud_nxt;
    logic [7:0]  flt_r,   flt_nxt;
    logic [12:0] m1_r,    m1_nxt;
    logic [12:0] m2_r,    m2_nxt;
    logic [12:0] m3_r,    m3_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        rvalid_r;
    logic [3:0]  cke_r,   cke_nxt;
    logic [3:0]  pke_r,   pke_nxt;
    logic [2:0]  spol_r,  spol_nxt;
    logic        pol_meta_r;
    logic        pol_sync_r;
    logic        restore;

    always_comb begin
        restore   = wr_i && addr_i == DEV_CTRL_OFS && wdata_i[RESTORE_BIT];
        ctrl_nxt  = ctrl_r;
        pol_nxt   = pol_r;
        fmta_nxt  = fmta_r;
        fmtb_nxt  = fmtb_r;
        aud_nxt   = aud_r;
        flt_nxt   = flt_r;
        m1_nxt    = m1_r;
        m2_nxt    = m2_r;
        m3_nxt    = m3_r;
        if (restore) begin
            ctrl_nxt = DEV_CTRL_RST;
            pol_nxt  = IN_POL_RST;
            fmta_nxt = VID_A_FMT_RST;
            fmtb_nxt = VID_B_FMT_RST;
            aud_nxt  = AUD_XPT_RST;
            flt_nxt  = OUT_FLOAT_RST;
            m1_nxt   = MARK_RST;
            m2_nxt   = MARK_RST;
            m3_nxt   = MARK_RST;
        end else if (wr_i) begin
            unique case (addr_i)
                DEV_CTRL_OFS:  ctrl_nxt = wdata_i[6:0];
                IN_POL_OFS:    pol_nxt  = wdata_i[3:0];
                VID_A_FMT_OFS: fmta_nxt = wdata_i[5:0];
                VID_B_FMT_OFS: fmtb_nxt = wdata_i[5:0];
                AUD_XPT_OFS:   aud_nxt  = wdata_i[4:0];
                OUT_FLOAT_OFS: flt_nxt  = wdata_i;
                MARK1_HI_OFS:  m1_nxt   = {wdata_i[4:0], m1_r[7:0]};
                MARK1_LO_OFS:  m1_nxt   = {m1_r[12:8], wdata_i};
                MARK2_HI_OFS:  m2_nxt   = {wdata_i[4:0], m2_r[7:0]};
                MARK2_LO_OFS:  m2_nxt   = {m2_r[12:8], wdata_i};
                MARK3_HI_OFS:  m3_nxt   = {wdata_i[4:0], m3_r[7:0]};
                MARK3_LO_OFS:  m3_nxt   = {m3_r[12:8], wdata_i};
                default:       ;
            endcase
        end
    end

    // Read path; unmapped offsets read zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_i) begin
            unique case (addr_i)
                DEV_CTRL_OFS:  rdata_nxt = {1'b0, ctrl_r};
                IN_POL_OFS:    rdata_nxt = {4'h0, pol_r};
                VID_A_FMT_OFS: rdata_nxt = {2'h0, fmta_r};
                VID_B_FMT_OFS: rdata_nxt = {2'h0, fmtb_r};
                AUD_XPT_OFS:   rdata_nxt = {3'h0, aud_r};
                OUT_FLOAT_OFS: rdata_nxt = flt_r;
                MARK1_HI_OFS:  rdata_nxt = {3'h0, m1_r[12:8]};
                MARK1_LO_OFS:  rdata_nxt = m1_r[7:0];
                MARK2_HI_OFS:  rdata_nxt = {3'h0, m2_r[12:8]};
                MARK2_LO_OFS:  rdata_nxt = m2_r[7:0];
                MARK3_HI_OFS:  rdata_nxt = {3'h0, m3_r[12:8]};
                MARK3_LO_OFS:  rdata_nxt = m3_r[7:0];
                default:       rdata_nxt = 8'h00;
            endcase
        end
    end

    // Pin enables follow the next register values so they settle with them
    always_comb begin
        // drive only when enabled and not floated
        cke_nxt = ctrl_nxt[ALL_ON_BIT] ? ~flt_nxt[7:4] : 4'h0;
        pke_nxt = ctrl_nxt[ALL_ON_BIT] ? ~flt_nxt[3:0] : 4'h0;
        // auto polarity copies line sync result
        spol_nxt = pol_nxt[AUTO_POL_BIT] ? {3{pol_sync_r}} : pol_nxt[2:0];
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_r     <= DEV_CTRL_RST;
            pol_r      <= IN_POL_RST;
            fmta_r     <= VID_A_FMT_RST;
            fmtb_r     <= VID_B_FMT_RST;
            aud_r      <= AUD_XPT_RST;
            flt_r      <= OUT_FLOAT_RST;
            m1_r       <= MARK_RST;
            m2_r       <= MARK_RST;
            m3_r       <= MARK_RST;
            rdata_r    <= 8'h00;
            rvalid_r   <= 1'b0;
            // Match the default enable and float bits so pins agree
            cke_r      <= DEV_CTRL_RST[ALL_ON_BIT] ?
                          ~OUT_FLOAT_RST[7:4] : 4'h0;
            pke_r      <= DEV_CTRL_RST[ALL_ON_BIT] ?
                          ~OUT_FLOAT_RST[3:0] : 4'h0;
            spol_r     <= 3'h0;
            pol_meta_r <= 1'b0;
            pol_sync_r <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            pol_r      <= pol_nxt;
            fmta_r     <= fmta_nxt;
            fmtb_r     <= fmtb_nxt;
            aud_r      <= aud_nxt;
            flt_r      <= flt_nxt;
            m1_r       <= m1_nxt;
            m2_r       <= m2_nxt;
            m3_r       <= m3_nxt;
            rdata_r    <= rdata_nxt;
            rvalid_r   <= rd_i;
            cke_r      <= cke_nxt;
            pke_r      <= pke_nxt;
            spol_r     <= spol_nxt;
            pol_meta_r <= detected_line_pol_i;
            pol_sync_r <= pol_meta_r;
        end
    end

    assign rdata_o  = rdata_r;
    assign rvalid_o = rvalid_r;
    assign sleep_port_o           = ctrl_r[SLEEP_BIT];
    assign format_autodetect_on_o = ctrl_r[AUTODET_BIT];
    assign reference_loop_mode_o  = ctrl_r[LOOP_MODE_HI:LOOP_MODE_LO];
    assign ref_loss_policy_o      = ctrl_r[LOSS_POL_BIT];
    assign force_full_rate_o      = ctrl_r[FULL_RATE_BIT];
    assign sync_polarity_o        = spol_r;
    assign video_a_format_o       = fmta_r;
    assign video_b_format_o       = fmtb_r;
    // user and unknown code flags, kept as registers
    logic user_r, unk_r;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            user_r <= 1'b0;
            unk_r  <= 1'b0;
        end else begin
            user_r <= fmta_nxt == FMT_USER;
            unk_r  <= fmta_nxt == FMT_UNKNOWN;
        end
    end
    assign video_a_user_o      = user_r;
    assign video_a_unknown_o   = unk_r;
    assign aux4_pulse_select_o = aud_r[AUX4_BIT];
    assign crosspoint_select_o = aud_r[3:0];
    assign clock_pin_oe_o      = cke_r;
    assign pulse_pin_oe_o      = pke_r;
    assign mark1_line_delay_o  = m1_r;
    assign mark2_line_delay_o  = m2_r;
    assign mark3_line_delay_o  = m3_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_restore_wr;
        wr_i && addr_i == DEV_CTRL_OFS && wdata_i[RESTORE_BIT];
    endsequence
    sequence s_ctrl_rd;
        rd_i && addr_i == DEV_CTRL_OFS ##1 rvalid_o;
    endsequence
    sequence s_pol_rd;
        rd_i && addr_i == IN_POL_OFS ##1 rvalid_o;
    endsequence

    AST_RESTORE: assert property (s_restore_wr |=>
        ctrl_r == DEV_CTRL_RST && flt_r == OUT_FLOAT_RST && m1_r == 13'h0)
        else $error("restore did not reset registers");
    AST_CTRL_RD0: assert property (s_ctrl_rd |-> !rdata_o[7])
        else $error("restore bit read back as one");
    AST_SLEEP: assert property ((wr_i && addr_i == DEV_CTRL_OFS &&
        !wdata_i[7]) |=> sleep_port_o == $past(wdata_i[6]))
        else $error("sleep port not following write");
    AST_RST_DEF: assert property (@(posedge clk_i) disable iff (1'b0)
        reset_i |=> format_autodetect_on_o && ref_loss_policy_o &&
        reference_loop_mode_o == LOOP_FREE_RUN && pulse_pin_oe_o == 4'h0)
        else $error("wrong control defaults after reset");
    AST_LOOP_MODE: assert property ((wr_i && addr_i == DEV_CTRL_OFS &&
        !wdata_i[7]) |=> reference_loop_mode_o == $past(wdata_i[4:3]))
        else $error("loop mode not updated");
    AST_PIN_OE: assert property (
        clock_pin_oe_o == (ctrl_r[0] ? ~flt_r[7:4] : 4'h0) &&
        pulse_pin_oe_o == (ctrl_r[0] ? ~flt_r[3:0] : 4'h0))
        else $error("pin enable disagrees with controls");
    AST_MAN_POL: assert property (!pol_r[AUTO_POL_BIT] &&
        $stable(pol_r) |-> sync_polarity_o == pol_r[2:0])
        else $error("manual polarity not applied");
    AST_RSVD_RD: assert property (s_pol_rd |-> rdata_o[7:4] == 4'h0)
        else $error("reserved polarity bits not zero");
    AST_MARK1_HI: assert property ((wr_i && addr_i == MARK1_HI_OFS)
        |=> mark1_line_delay_o[12:8] == $past(wdata_i[4:0]) &&
        $stable(mark1_line_delay_o[7:0]))
        else $error("mark 1 high write wrong");

    sequence s_ctrl_wr;
        wr_i && addr_i == DEV_CTRL_OFS && !wdata_i[RESTORE_BIT];
    endsequence

    AST_AUTODET: assert property (s_ctrl_wr |=>
        format_autodetect_on_o == $past(wdata_i[AUTODET_BIT]))
        else $error("autodetect enable not following write");
    AST_LOSS_POL: assert property (s_ctrl_wr |=>
        ref_loss_policy_o == $past(wdata_i[LOSS_POL_BIT]))
        else $error("loss policy not following write");
    AST_FULL_RATE: assert property (s_ctrl_wr |=>
        force_full_rate_o == $past(wdata_i[FULL_RATE_BIT]))
        else $error("full rate force not following write");
    AST_AUTO_POL: assert property (pol_r[AUTO_POL_BIT] &&
        $stable(pol_r) && $stable(pol_sync_r) |->
        sync_polarity_o == {3{pol_sync_r}})
        else $error("detected polarity not applied");
    AST_FMT_A: assert property ((wr_i && addr_i == VID_A_FMT_OFS) |=>
        video_a_format_o == $past(wdata_i[5:0]))
        else $error("video A format not updated");
    AST_FMT_FLAGS: assert property (
        video_a_user_o == (video_a_format_o == FMT_USER) &&
        video_a_unknown_o == (video_a_format_o == FMT_UNKNOWN))
        else $error("format code flags wrong");
    AST_AUD_XPT: assert property ((wr_i && addr_i == AUD_XPT_OFS) |=>
        crosspoint_select_o == $past(wdata_i[3:0]) &&
        aux4_pulse_select_o == $past(wdata_i[AUX4_BIT]))
        else $error("audio and crosspoint mode not updated");
    AST_MARK2_LO: assert property ((wr_i && addr_i == MARK2_LO_OFS)
        |=> mark2_line_delay_o[7:0] == $past(wdata_i) &&
        $stable(mark2_line_delay_o[12:8]))
        else $error("mark 2 low write wrong");
    AST_MARK3_HI: assert property ((wr_i && addr_i == MARK3_HI_OFS)
        |=> mark3_line_delay_o[12:8] == $past(wdata_i[4:0]) &&
        $stable(mark3_line_delay_o[7:0]))
        else $error("mark 3 high write wrong");
endmodule : clkgen_regs
`default_nettype wire

// file: host_model.sv
// Host model: issues byte writes and reads on the register port.
// Assumes the bank samples strobes on the rising edge of clk_i.
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output var  logic       wr_o,
    output var  logic       rd_o,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        // Released lines must not keep their last value
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q,
                      output logic v);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        q = rdata_i;
        v = rvalid_i;
    endtask : rd
endmodule : host_model
`default_nettype wire

// file: clkgen_regs_test.sv
// Self-checking bench for the clock generator register bank.
// Assumes host_model drives the port; polarity detector is a plain input.
`timescale 1ns/10ps
`default_nettype none
module clkgen_regs_test;
    import clkgen_regs_pkg::*;
    typedef struct {
        logic [7:0] addr;
        logic [7:0] dflt;
        logic [7:0] wdata;
        logic [7:0] rback;
    } row_s;
    logic        clk, reset, det_pol, wr, rd, rvalid, v;
    logic        sleep, afd, loss, full, user, unk, aux4;
    logic [1:0]  mode;
    logic [2:0]  pol;
    logic [3:0]  xpt, ck_oe, pl_oe;
    logic [5:0]  fmt_a, fmt_b;
    logic [7:0]  addr, wdata, rdata, q;
    logic [12:0] m1, m2, m3;
    int          err_total, total_checks;
    row_s        rows [13];

    clkgen_regs u_dut (.clk_i(clk), .reset_i(reset), .wr_i(wr), .rd_i(rd),
        .addr_i(addr), .wdata_i(wdata), .detected_line_pol_i(det_pol),
        .rdata_o(rdata), .rvalid_o(rvalid), .sleep_port_o(sleep),
        .format_autodetect_on_o(afd), .reference_loop_mode_o(mode),
        .ref_loss_policy_o(loss), .force_full_rate_o(full),
        .sync_polarity_o(pol), .video_a_format_o(fmt_a),
        .video_a_user_o(user), .video_a_unknown_o(unk),
        .video_b_format_o(fmt_b), .aux4_pulse_select_o(aux4),
        .crosspoint_select_o(xpt), .clock_pin_oe_o(ck_oe),
        .pulse_pin_oe_o(pl_oe), .mark1_line_delay_o(m1),
        .mark2_line_delay_o(m2), .mark3_line_delay_o(m3));
    host_model u_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
        .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));

    task automatic chk(input string n, input logic [15:0] s, e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rb(input logic [7:0] a, input logic [7:0] e);
        u_host.rd(a, q, v);
        chk("rvalid", 16'(v), 16'h0001);
        chk($sformatf("reg %h", a), 16'(q), 16'(e));
    endtask : rb
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        // About 125 bus cycles are needed; the margin is generous
        #(25 * 4000);
        err_total++;
        conclude();
    end
    initial begin
        reset = 1'b1;
        det_pol = 1'b1;
        err_total = 0;
        total_checks = 0;
        rows = '{'{8'h05, 8'h25, 8'h5E, 8'h5E}, '{8'h06, 8'h08, 8'hF5, 8'h05},
            '{8'h07, 8'h0E, 8'hFF, 8'h3F}, '{8'h08, 8'h0E, 8'hC1, 8'h01},
            '{8'h09, 8'h00, 8'hFF, 8'h1F}, '{8'h0A, 8'h0F, 8'hA5, 8'hA5},
            '{8'h0B, 8'h00, 8'hFF, 8'h1F}, '{8'h0C, 8'h00, 8'hA5, 8'hA5},
            '{8'h0D, 8'h00, 8'h13, 8'h13}, '{8'h0E, 8'h00, 8'h5A, 8'h5A},
            '{8'h0F, 8'h00, 8'h0A, 8'h0A}, '{8'h10, 8'h00, 8'hFF, 8'hFF},
            '{8'h04, 8'h00, 8'hFF, 8'h00}};
        repeat (12) @(negedge clk);
        reset = 1'b0;
        chk("oe", 16'({ck_oe, pl_oe}), 16'h00F0);
        chk("pol", 16'(pol), 16'h0000);
        // Detector reaches the applied polarity through two sync stages and the output register
        repeat (3) @(negedge clk);
        chk("pol", 16'(pol), 16'h0007);
        chk("oe", 16'({ck_oe, pl_oe}), 16'h00F0);
        $display("done: reset defaults");
        foreach (rows[i]) begin
            rb(rows[i].addr, rows[i].dflt);
            u_host.wr(rows[i].addr, rows[i].wdata);
            rb(rows[i].addr, rows[i].rback);
        end
        chk("ctrl", 16'({sleep, afd, mode, loss, full}), 16'h002F);
        chk("oe", 16'({ck_oe, pl_oe}), 16'h0000);
        chk("pol", 16'(pol), 16'h0005);
        chk("fmt", 16'({unk, user, fmt_a}), 16'h00BF);
        chk("fmt_b", 16'(fmt_b), 16'h0001);
        chk("aud", 16'({aux4, xpt}), 16'h001F);
        chk("m1", 16'(m1), 16'h1FA5);
        chk("m2", 16'(m2), 16'h135A);
        chk("m3", 16'(m3), 16'h0AFF);
        $display("done: register table");
        for (int m = 0; m < 4; m++) begin
            u_host.wr(8'h05, 8'((m << 3) | 1));
            chk("mode", 16'(mode), 16'(m));
        end
        u_host.wr(8'h0A, 8'h5A);
        chk("oe", 16'({ck_oe, pl_oe}), 16'h00A5);
        u_host.wr(8'h05, 8'h18);
        chk("oe", 16'({ck_oe, pl_oe}), 16'h0000);
        $display("done: modes and pins");
        u_host.wr(8'h06, 8'h08);
        det_pol = 1'b0;
        repeat (4) @(negedge clk);
        chk("pol", 16'(pol), 16'h0000);
        u_host.wr(8'h07, 8'h1F);
        chk("fmt", 16'({unk, user}), 16'h0001);
        $display("done: polarity and format");
        u_host.wr(8'h05, 8'hDE);
        rb(8'h05, 8'h25);
        rb(8'h0A, 8'h0F);
        chk("m1", 16'(m1), 16'h0000);
        chk("fmt", 16'(fmt_a), 16'h000E);
        $display("done: restore");
        u_host.wr(8'h0E, 8'h77);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        rb(8'h0E, 8'h00);
        chk("m2", 16'(m2), 16'h0000);
        $display("done: second reset");
        conclude();
    end
endmodule : clkgen_regs_test
`default_nettype wire
